// *** core/dbs_defs.svh ***
// Constants for the double-rate burst-of-four memory port.
// Overview of operation
// - Read and write addresses share one bus, both sampled on positive link clock edges.
// - Every read and write moves exactly four beats; burst length is fixed.
// - Read beats one and three leave on the third and fourth positive edges.
// - Read beats two and four leave on the third and fourth complementary edges.
// - Positive edges capture address, strobes, enables and data of beats one and three.
// - Complementary edges capture enables and data of beats two and four.
// - Byte enables travel with each beat and may change between beats.
// - A write takes two cycles; one write command at most every two cycles.
// - A read takes two cycles; one read command at most every two cycles.
// - Read and write ports work independently and concurrently, without turnaround.
// - Read and write data move one beat per edge of the clock pair.
// - Echo clocks are driven with edges matched to the read data.
// - A flag marks when the read data bus carries valid data.
// - Data is 36 bits wide in the wide organisation, 18 in the narrow.
// - A low strobe at a positive edge registers the address and starts a burst.
// - Byte enables are active low; a low enable writes that byte.
// - The read valid flag changes together with the echo clock edges.
// - A low loop-disable input selects the shorter read latency for slow clocks.
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH

`define DBS_DW 36
`define DBS_BW 4
`define DBS_LANE 9
`define DBS_AW 19
`define DBS_MEM_AW 20
`define DBS_MEM_DEPTH 1048576
`define DBS_BURST 4
`define DBS_FIFO_DEPTH 8
`define DBS_CLK_MHZ 25
`define DBS_DLL_OFF_MAX_MHZ 167

`define DBS_PIN_KP 0
`define DBS_PIN_KN 1
`define DBS_PIN_DLL 2
`define DBS_PIN_RD 3
`define DBS_PIN_WR 4
`define DBS_PIN_ADDR 5
`define DBS_PIN_DATA 24
`define DBS_PIN_BE 60
`define DBS_PIN_W 64
`define DBS_LVL_W 3
`define DBS_PIN_IDLE 64'h0000_0000_0000_0018

`endif

// *** core/dbs_fifo.sv ***
// Read beat buffer with parameter width and depth.
`timescale 1ns/1ps
`default_nettype none
module dbs_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	input  wire logic    clk_i,
	input  wire logic    srst_i,
	dbs_stream_if.sink   fill,
	dbs_stream_if.source drain
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	assign fill.ready  = (count != (PW+1)'(DEPTH));
	assign drain.valid = (count != '0);
	assign drain.data  = store[rd_ptr];
	assign push        = fill.valid & fill.ready;
	assign pop         = drain.valid & drain.ready;

	always_ff @(posedge clk_i) begin
		if (push) begin
			store[wr_ptr] <= fill.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** core/dbs_pkg.sv ***
// Types used by the memory port for its pins, storage and read fetch.
`include "dbs_defs.svh"
package dbs_pkg;
	typedef logic [`DBS_DW-1:0] dbs_data_t;
	typedef logic [`DBS_BW-1:0] dbs_be_t;
	typedef logic [`DBS_AW-1:0] dbs_addr_t;
	typedef logic [`DBS_MEM_AW-1:0] dbs_midx_t;
	typedef logic [1:0] dbs_beat_t;
	typedef enum logic [1:0] {
		DBS_FETCH_IDLE = 2'h1,
		DBS_FETCH_RUN  = 2'h2
	} dbs_fetch_e;
endpackage

// *** core/dbs_port.sv ***
// Memory core with separate double-rate read and write ports, burst of four.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_port #(
	parameter bit WIDE = 1'b1
) (
	input  wire logic                CLOCK_I,
	input  wire logic                SRST_I,
	input  wire logic                LINK_CLK_P_I,
	input  wire logic                LINK_CLK_N_I,
	input  wire logic                DLL_OFF_N_I,
	input  wire logic                READ_N_I,
	input  wire logic                WRITE_N_I,
	input  wire logic [`DBS_AW-1:0]  ADDR_IN_I,
	input  wire logic [`DBS_DW-1:0]  WRITE_DATA_IN_I,
	input  wire logic [`DBS_BW-1:0]  BYTE_ENABLE_N_I,
	output logic      [`DBS_DW-1:0]  READ_DATA_OUT_O,
	output logic                     ECHO_TICK_POS_O,
	output logic                     ECHO_TICK_NEG_O,
	output logic                     READ_VALID_FLAG_O
);

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------

	logic [`DBS_PIN_W-1:0] pin_bus;
	logic [`DBS_PIN_W-1:0] pin_s1;
	logic [`DBS_PIN_W-1:0] pin_s2;
	logic [`DBS_PIN_W-1:0] pin_s3;
	logic [`DBS_LVL_W-1:0] lvl;
	logic [`DBS_LVL_W-1:0] rise;

	assign pin_bus = {BYTE_ENABLE_N_I, WRITE_DATA_IN_I, ADDR_IN_I, WRITE_N_I, READ_N_I,
		DLL_OFF_N_I, LINK_CLK_N_I, LINK_CLK_P_I};

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			pin_s1 <= `DBS_PIN_IDLE;
			pin_s2 <= `DBS_PIN_IDLE;
			pin_s3 <= `DBS_PIN_IDLE;
		end else begin
			pin_s1 <= pin_bus;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// Each clock and the loop-disable level change once two stages agree.
	genvar gl;
	generate
		for (gl = 0; gl < `DBS_LVL_W; gl++) begin : g_lvl
			always_ff @(posedge CLOCK_I) begin
				if (SRST_I) begin
					lvl[gl] <= 1'b0;
				end else if (pin_s2[gl] == pin_s3[gl]) begin
					lvl[gl] <= pin_s3[gl];
				end
			end
			assign rise[gl] = pin_s2[gl] & pin_s3[gl] & ~lvl[gl];
		end
	endgenerate

	logic                kp_rise;
	logic                kn_rise;
	logic                any_edge;
	logic                dll_on;
	logic                rd_n;
	logic                wr_n;
	dbs_pkg::dbs_addr_t  pin_addr;
	dbs_pkg::dbs_data_t  pin_data;
	dbs_pkg::dbs_be_t    pin_be_n;

	assign kp_rise  = rise[`DBS_PIN_KP];
	assign kn_rise  = rise[`DBS_PIN_KN];
	assign any_edge = kp_rise | kn_rise;
	assign dll_on   = lvl[`DBS_PIN_DLL];
	assign rd_n     = pin_s3[`DBS_PIN_RD];
	assign wr_n     = pin_s3[`DBS_PIN_WR];
	assign pin_addr = pin_s3[`DBS_PIN_ADDR +: `DBS_AW];
	assign pin_data = pin_s3[`DBS_PIN_DATA +: `DBS_DW];
	assign pin_be_n = pin_s3[`DBS_PIN_BE +: `DBS_BW];

	// ------------------------------------------------------------
	// Write command pipeline
	// ------------------------------------------------------------

	logic               wq_v;
	logic               wa_v;
	logic               wb_v;
	dbs_pkg::dbs_addr_t wq_addr;
	dbs_pkg::dbs_addr_t wa_addr;
	dbs_pkg::dbs_addr_t wb_addr;

	// A command waits in stage q until beat one.
	// Stage a then holds beats two and three, stage b beat four.
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			wq_v    <= 1'b0;
			wa_v    <= 1'b0;
			wb_v    <= 1'b0;
			wq_addr <= '0;
			wa_addr <= '0;
			wb_addr <= '0;
		end else if (kp_rise) begin
			wb_v    <= wa_v;
			wb_addr <= wa_addr;
			wa_v    <= wq_v;
			wa_addr <= wq_addr;
			wq_v    <= !wr_n && !wq_v;
			wq_addr <= pin_addr;
		end
	end

	logic               beat_go;
	dbs_pkg::dbs_beat_t beat_idx;
	dbs_pkg::dbs_addr_t beat_addr;
	dbs_pkg::dbs_midx_t beat_midx;

	// Beat order follows the edge: a positive edge takes beat one or three.
	always_comb begin
		beat_go   = 1'b0;
		beat_idx  = 2'h0;
		beat_addr = wq_addr;
		if (kp_rise && wq_v) begin
			beat_go   = 1'b1;
			beat_idx  = 2'h0;
			beat_addr = wq_addr;
		end else if (kp_rise && wa_v) begin
			beat_go   = 1'b1;
			beat_idx  = 2'h2;
			beat_addr = wa_addr;
		end else if (kn_rise && wa_v) begin
			beat_go   = 1'b1;
			beat_idx  = 2'h1;
			beat_addr = wa_addr;
		end else if (kn_rise && wb_v) begin
			beat_go   = 1'b1;
			beat_idx  = 2'h3;
			beat_addr = wb_addr;
		end
	end

	assign beat_midx = WIDE ? {beat_addr[`DBS_AW-2:0], beat_idx} : {beat_addr[`DBS_AW-1:1], beat_idx};

	// ------------------------------------------------------------
	// Storage and byte merge
	// ------------------------------------------------------------

	dbs_pkg::dbs_data_t mem [`DBS_MEM_DEPTH];
	dbs_pkg::dbs_data_t cur_word;
	dbs_pkg::dbs_data_t merged;
	logic [`DBS_BW-1:0] lane_we;

	assign cur_word = mem[beat_midx];

	genvar gb;
	generate
		for (gb = 0; gb < `DBS_BW; gb++) begin : g_lane
			localparam int SRC = WIDE ? gb : (gb % 2);
			logic half_hit;
			assign half_hit    = WIDE ? 1'b1 : (beat_addr[0] == ((gb / 2) == 1));
			assign lane_we[gb] = half_hit && !pin_be_n[SRC];
			assign merged[gb*`DBS_LANE +: `DBS_LANE] = lane_we[gb] ?
				pin_data[SRC*`DBS_LANE +: `DBS_LANE] : cur_word[gb*`DBS_LANE +: `DBS_LANE];
		end
	endgenerate

	always_ff @(posedge CLOCK_I) begin
		if (beat_go) begin
			mem[beat_midx] <= merged;
		end
	end

	// ------------------------------------------------------------
	// Read command pipeline
	// ------------------------------------------------------------

	logic               r1_v;
	logic               r2_v;
	dbs_pkg::dbs_addr_t r1_addr;
	dbs_pkg::dbs_addr_t r2_addr;

	// The read pipeline runs beside the write one with no shared state.
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			r1_v    <= 1'b0;
			r2_v    <= 1'b0;
			r1_addr <= '0;
			r2_addr <= '0;
		end else if (kp_rise) begin
			r2_v    <= r1_v;
			r2_addr <= r1_addr;
			r1_v    <= !rd_n && !r1_v;
			r1_addr <= pin_addr;
		end
	end

	logic               due_v;
	dbs_pkg::dbs_addr_t due_addr;

	// With the loop disabled the burst leaves one cycle sooner.
	assign due_v    = dll_on ? r2_v : r1_v;
	assign due_addr = dll_on ? r2_addr : r1_addr;

	// ------------------------------------------------------------
	// Fetch into the read buffer
	// ------------------------------------------------------------

	dbs_stream_if #(.W(`DBS_DW)) fill_s ();
	dbs_stream_if #(.W(`DBS_DW)) drain_s ();

	dbs_pkg::dbs_fetch_e fetch_state;
	dbs_pkg::dbs_beat_t  f_idx;
	dbs_pkg::dbs_addr_t  f_addr;
	dbs_pkg::dbs_midx_t  f_midx;
	dbs_pkg::dbs_data_t  f_word;
	dbs_pkg::dbs_data_t  f_out;

	assign f_midx = WIDE ? {f_addr[`DBS_AW-2:0], f_idx} : {f_addr[`DBS_AW-1:1], f_idx};

	// A beat written in the same cycle is forwarded to the fetch.
	assign f_word = (beat_go && beat_midx == f_midx) ? merged : mem[f_midx];

	always_comb begin
		f_out = '0;
		if (WIDE) begin
			f_out = f_word;
		end else if (f_addr[0]) begin
			f_out[`DBS_DW/2-1:0] = f_word[`DBS_DW-1:`DBS_DW/2];
		end else begin
			f_out[`DBS_DW/2-1:0] = f_word[`DBS_DW/2-1:0];
		end
	end

	assign fill_s.valid = (fetch_state == dbs_pkg::DBS_FETCH_RUN);
	assign fill_s.data  = f_out;

	// The fetch starts half a cycle before the first beat is due.
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			fetch_state <= dbs_pkg::DBS_FETCH_IDLE;
			f_idx       <= '0;
			f_addr      <= '0;
		end else begin
			case (fetch_state)
				dbs_pkg::DBS_FETCH_IDLE: begin
					if (kn_rise && due_v) begin
						fetch_state <= dbs_pkg::DBS_FETCH_RUN;
						f_idx       <= '0;
						f_addr      <= due_addr;
					end
				end
				dbs_pkg::DBS_FETCH_RUN: begin
					if (fill_s.ready) begin
						f_idx <= f_idx + 1'b1;
						if (f_idx == 2'(`DBS_BURST - 1)) begin
							fetch_state <= dbs_pkg::DBS_FETCH_IDLE;
						end
					end
				end
				default: begin
					fetch_state <= dbs_pkg::DBS_FETCH_IDLE;
				end
			endcase
		end
	end

	dbs_fifo #(
		.WIDTH (`DBS_DW),
		.DEPTH (`DBS_FIFO_DEPTH)
	) u_fifo (
		.clk_i  (CLOCK_I),
		.srst_i (SRST_I),
		.fill   (fill_s),
		.drain  (drain_s)
	);

	// ------------------------------------------------------------
	// Read output
	// ------------------------------------------------------------

	logic       start;
	logic [1:0] out_left;
	logic       pop;

	assign start         = kp_rise && due_v;
	assign pop           = start || (any_edge && out_left != 2'h0);
	assign drain_s.ready = pop;

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			out_left <= 2'h0;
		end else if (start) begin
			out_left <= 2'(`DBS_BURST - 1);
		end else if (any_edge && out_left != 2'h0) begin
			out_left <= out_left - 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			READ_DATA_OUT_O <= '0;
		end else if (pop && drain_s.valid) begin
			READ_DATA_OUT_O <= drain_s.data;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			READ_VALID_FLAG_O <= 1'b0;
		end else if (any_edge) begin
			READ_VALID_FLAG_O <= pop && drain_s.valid;
		end
	end

	// Echo clocks follow the filtered input pair and update with the data.
	assign ECHO_TICK_POS_O = lvl[`DBS_PIN_KP];
	assign ECHO_TICK_NEG_O = lvl[`DBS_PIN_KN];

endmodule
`default_nettype wire

// *** core/dbs_stream_if.sv ***
// Valid and ready stream between the port and its read buffer.
`timescale 1ns/1ps
`default_nettype none
interface dbs_stream_if #(parameter int W = 36);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** test/dbs_ctl_model.sv ***
// Controller model that plays a scheduled pin sequence on the link clock pair.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_ctl_model (
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	output logic                    link_p_o,
	output logic                    link_n_o,
	output logic                    read_n_o,
	output logic                    write_n_o,
	output logic    [`DBS_AW-1:0]   addr_o,
	output logic    [`DBS_DW-1:0]   data_o,
	output logic    [`DBS_BW-1:0]   be_n_o
);
	bit [`DBS_AW+2:0]         cmd [256];
	bit [`DBS_DW+`DBS_BW:0]   dat [256];
	int                       t;
	int                       e;
	// ----------------------------------------
	// Slot loading and playback, pins change mid half period.
	// ----------------------------------------
	task automatic put_cmd(input int k, input logic [`DBS_AW+1:0] v);
		cmd[k] = {1'h1, v};
	endtask
	task automatic put_dat(input int k, input logic [`DBS_DW+`DBS_BW-1:0] v);
		dat[k] = {1'h1, v};
	endtask
	initial {link_p_o, link_n_o, read_n_o, write_n_o, addr_o, data_o, be_n_o} = {2'h0, 2'h3, 19'h0, 36'h0, 4'hF};
	always @(posedge clk_i) begin
		#1;
		t = srst_i ? 0 : t + 1;
		link_p_o = t >= 8 && t % 8 < 4;
		link_n_o = t >= 8 && t % 8 >= 4;
		if (t >= 6 && t % 4 == 2 && t < 1000) begin
			e = (t - 6) / 4;
			{read_n_o, write_n_o} = 2'h3;
			if (cmd[e][`DBS_AW+2]) {read_n_o, write_n_o, addr_o} = cmd[e][`DBS_AW+1:0];
			else addr_o = ~addr_o;
			if (dat[e][`DBS_DW+`DBS_BW]) {data_o, be_n_o} = dat[e][`DBS_DW+`DBS_BW-1:0];
			else {data_o, be_n_o} = {~data_o, 4'hF};
		end
	end
endmodule
`default_nettype wire

// *** test/dbs_port_asserts.sv ***
// Concurrent checks on the pins of the memory port.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_port_asserts (
	input wire logic               CLOCK_I,
	input wire logic               SRST_I,
	input wire logic               LINK_CLK_P_I,
	input wire logic               LINK_CLK_N_I,
	input wire logic               DLL_OFF_N_I,
	input wire logic               READ_N_I,
	input wire logic [`DBS_DW-1:0] READ_DATA_OUT_O,
	input wire logic               ECHO_TICK_POS_O,
	input wire logic               ECHO_TICK_NEG_O,
	input wire logic               READ_VALID_FLAG_O
);
	logic [5:0] rd_age;
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	// ----------------------------------------
	// Cycles since the last read strobe and the checks.
	// ----------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) rd_age <= 6'h3F;
		else if ($rose(LINK_CLK_P_I) && !READ_N_I) rd_age <= 6'h00;
		else if (rd_age != 6'h3F) rd_age <= rd_age + 6'h01;
	end
	AST_ECHO_P: assert property ($rose(ECHO_TICK_POS_O) |-> $past(LINK_CLK_P_I, 4) && !$past(LINK_CLK_P_I, 5))
		else $error("positive echo not aligned to link edge");
	AST_ECHO_N: assert property ($rose(ECHO_TICK_NEG_O) |-> $past(LINK_CLK_N_I, 4) && !$past(LINK_CLK_N_I, 5))
		else $error("negative echo not aligned to link edge");
	AST_ECHO_PAIR: assert property (ECHO_TICK_POS_O |-> !ECHO_TICK_NEG_O)
		else $error("echo clocks not complementary");
	AST_DATA_EDGE: assert property (!$stable(READ_DATA_OUT_O) |-> $changed(ECHO_TICK_POS_O))
		else $error("read data changed away from an echo edge");
	AST_VALID_EDGE: assert property ($changed(READ_VALID_FLAG_O) |-> $changed(ECHO_TICK_POS_O))
		else $error("valid changed away from an echo edge");
	AST_LAT_ON: assert property ($rose(LINK_CLK_P_I) && !READ_N_I && DLL_OFF_N_I |-> ##20 READ_VALID_FLAG_O)
		else $error("read data late in normal mode");
	AST_LAT_OFF: assert property ($rose(LINK_CLK_P_I) && !READ_N_I && !DLL_OFF_N_I |-> ##12 READ_VALID_FLAG_O)
		else $error("read data late in loop off mode");
	AST_BURST: assert property ($rose(READ_VALID_FLAG_O) |-> READ_VALID_FLAG_O [*8] ##1 READ_VALID_FLAG_O [*8])
		else $error("valid burst shorter than four beats");
	AST_NO_READ: assert property (READ_VALID_FLAG_O |-> rd_age <= 6'h22)
		else $error("valid without a recent read");
	cover property ($rose(READ_VALID_FLAG_O) && DLL_OFF_N_I);
	cover property ($rose(READ_VALID_FLAG_O) && !DLL_OFF_N_I);
	cover property (READ_VALID_FLAG_O [*8] ##1 READ_VALID_FLAG_O [*8] ##1 READ_VALID_FLAG_O);
endmodule
bind dbs_port dbs_port_asserts chk_u (.CLOCK_I, .SRST_I, .LINK_CLK_P_I, .LINK_CLK_N_I, .DLL_OFF_N_I, .READ_N_I,
	.READ_DATA_OUT_O, .ECHO_TICK_POS_O, .ECHO_TICK_NEG_O, .READ_VALID_FLAG_O);
`default_nettype wire

// *** test/dbs_port_tb.sv ***
// Bench for the memory port with a controller model and a reference memory.
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_port_tb;
	logic                 clk = 1'h0;
	logic                 srst = 1'h1;
	logic                 dll_n = 1'h1;
	logic                 p, n, rn, wn, ep, en, vld, last_ep;
	logic [`DBS_AW-1:0]   a;
	logic [`DBS_DW-1:0]   d, rd;
	logic [`DBS_BW-1:0]   be;
	logic [`DBS_DW-1:0]   mem [int];
	logic [`DBS_DW:0]     expq [$];
	bit [31:0]            rnd = 32'h00015BC4;
	int                   fail_count = 0;
	int                   checked = 0;
	int                   lr = -9;
	int                   lw = -9;
	// ----------------------------------------
	// Clock, instances, reference model and checks.
	// ----------------------------------------
	always #20 clk = ~clk;
	dbs_ctl_model ctl_u (.clk_i(clk), .srst_i(srst), .link_p_o(p), .link_n_o(n), .read_n_o(rn), .write_n_o(wn),
		.addr_o(a), .data_o(d), .be_n_o(be));
	dbs_port dut_u (.CLOCK_I(clk), .SRST_I(srst), .LINK_CLK_P_I(p), .LINK_CLK_N_I(n), .DLL_OFF_N_I(dll_n),
		.READ_N_I(rn), .WRITE_N_I(wn), .ADDR_IN_I(a), .WRITE_DATA_IN_I(d), .BYTE_ENABLE_N_I(be),
		.READ_DATA_OUT_O(rd), .ECHO_TICK_POS_O(ep), .ECHO_TICK_NEG_O(en), .READ_VALID_FLAG_O(vld));
	function automatic bit [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction
	task automatic cmp(input string nm, input logic [`DBS_DW:0] ex, input logic [`DBS_DW:0] got);
		checked++;
		if (got !== ex) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic go(input int k, input logic r, input logic w, input logic [`DBS_AW-1:0] ad, input bit full);
		logic [`DBS_DW-1:0] v;
		logic [`DBS_BW-1:0] b;
		logic [`DBS_DW-1:0] old [4];
		bit                 wok;
		wok = 1'b0;
		for (int i = 0; i < 4; i++) old[i] = mem.exists(ad * 4 + i) ? mem[ad * 4 + i] : 'x;
		ctl_u.put_cmd(k, {r, w, ad});
		if (!w && k != lw + 2) begin
			lw = k;
			wok = 1'b1;
			for (int i = 0; i < 4; i++) begin
				v = 36'({xs(), xs()});
				b = full ? 4'h0 : 4'(xs());
				ctl_u.put_dat(k + 2 + i, {v, b});
				for (int j = 0; j < 4; j++) if (!b[j]) mem[ad * 4 + i][j * 9 +: 9] = v[j * 9 +: 9];
			end
		end
		if (!r && k != lr + 2) begin
			lr = k;
			// Beats three and four of a write on the same edge land after the fetch.
			for (int i = 0; i < 4; i++) expq.push_back({i % 2 == 0, (wok && i >= 2) ? old[i] : mem[ad * 4 + i]});
		end
	endtask
	task automatic end_sim();
		if (expq.size() != 0) fail_count++;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		if (ep !== last_ep && vld === 1'h1) cmp("read beat", expq.size() ? expq.pop_front() : 37'hXXXXXXXXXX, {ep, rd});
		last_ep = ep;
	end
	initial begin
		logic [`DBS_AW-1:0] a0, a1;
		a0 = 19'(18'(xs()));
		a1 = a0 ^ 19'h00001;
		go(0, 1'h1, 1'h0, a0, 1'h1);
		go(2, 1'h1, 1'h0, a1, 1'h0);
		go(4, 1'h1, 1'h0, a1, 1'h1);
		go(8, 1'h1, 1'h0, a0, 1'h0);
		go(12, 1'h0, 1'h1, a0, 1'h0);
		go(14, 1'h0, 1'h1, a1, 1'h0);
		go(16, 1'h0, 1'h1, a0, 1'h0);
		go(20, 1'h0, 1'h0, a1, 1'h0);
		go(40, 1'h0, 1'h1, a0, 1'h0);
		go(42, 1'h0, 1'h1, a1, 1'h0);
		repeat (12) @(posedge clk);
		#1 srst = 1'h0;
		repeat (130) @(posedge clk);
		#1 dll_n = 1'h0;
		repeat (120) @(posedge clk);
		end_sim();
	end
	initial begin
		#40000;
		fail_count++;
		end_sim();
	end
endmodule
`default_nettype wire
